// [rtl/dce_error_status.sv]
// Error and status register bank of the disk controller.
// Assumes an APB master on clk_sys; drive inputs are
// synchronous and event inputs are one-cycle pulses.
`timescale 1ns/1ps
module dce_error_status (
	input wire logic clk_sys,
	input wire logic reset_n,
	input wire logic [7:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic driveReadyInput,
	input wire logic writeFaultInput,
	input wire logic seekDoneInput,
	input wire logic headAtOriginInput,
	input wire logic stepPulse,
	input wire logic badBlockSeen,
	input wire logic dataCrcFail,
	input wire logic headerMissing,
	input wire logic markMissing,
	input wire logic transferRequestInput,
	input wire logic dataCorrected,
	input wire logic commandDone,
	input wire logic bufferDrained,
	output logic commandStart,
	output logic [7:0] commandCode,
	output logic commandAbort,
	output logic interruptRequestOut
);
	dce_pkg::dce_state_t state;
	dce_pkg::dce_state_t next_state;
	logic [7:0] errFlags;
	logic [7:0] errSet;
	logic [7:0] statusWord;
	logic corrFlag;
	logic readyLatched;
	logic faultLatched;
	logic stepExpired;
	logic cmdAccept;
	logic codeKnown;
	logic isRead;
	logic isRestore;
	logic running;
	logic busy;
	logic abortNow;
	logic restoreFail;
	logic finish;
	logic mapped;

	////////////////////////////////////////////////////////////
	// APB slave

	assign mapped = (paddr == dce_pkg::ADDR_ERROR) ||
		(paddr == dce_pkg::ADDR_STATUS) ||
		(paddr == dce_pkg::ADDR_COMMAND);

	// Ready and read data are prepared in the setup cycle,
	// giving a registered answer with no wait states.
	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			pready <= 1'b0;
		end else begin
			pready <= psel && !penable;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			pslverr <= 1'b0;
		end else begin
			pslverr <= psel && !penable && !mapped;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			prdata <= 32'h0000_0000;
		end else if (psel && !penable && !pwrite) begin
			case (paddr)
				dce_pkg::ADDR_ERROR: begin
					prdata <= {24'h00_0000, errFlags & dce_pkg::ERR_USED_MASK};
				end
				dce_pkg::ADDR_STATUS: begin
					prdata <= {24'h00_0000, statusWord};
				end
				dce_pkg::ADDR_COMMAND: begin
					prdata <= {24'h00_0000, commandCode};
				end
				default: begin
					prdata <= 32'h0000_0000;
				end
			endcase
		end
	end

	// only the command register takes writes
	assign cmdAccept = psel && penable && pready && pwrite &&
		(paddr == dce_pkg::ADDR_COMMAND) && !busy;

	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			commandCode <= dce_pkg::RESET_BYTE;
		end else if (cmdAccept) begin
			commandCode <= pwdata[7:0];
		end
	end

	////////////////////////////////////////////////////////////
	// Command sequencing

	assign codeKnown = (commandCode[7:4] == dce_pkg::CMD_RESTORE) ||
		(commandCode[7:4] == dce_pkg::CMD_READ) ||
		(commandCode[7:4] == dce_pkg::CMD_WRITE) ||
		(commandCode[7:4] == dce_pkg::CMD_SEEK);
	assign isRead = commandCode[7:4] == dce_pkg::CMD_READ;
	assign isRestore = commandCode[7:4] == dce_pkg::CMD_RESTORE;

	assign running = (state == dce_pkg::ST_CHECK) ||
		(state == dce_pkg::ST_EXEC);
	// busy from write until back in idle, which for reads is after the buffer drains
	assign busy = state != dce_pkg::ST_IDLE;

	// abort on not ready, fault, unknown code
	always_comb begin
		abortNow = 1'b0;
		if (state == dce_pkg::ST_CHECK) begin
			abortNow = !codeKnown || !driveReadyInput || writeFaultInput;
		end else if (state == dce_pkg::ST_EXEC) begin
			abortNow = !driveReadyInput || writeFaultInput;
		end
	end

	// restore gives up after the step limit
	assign restoreFail = (state == dce_pkg::ST_EXEC) && isRestore &&
		stepExpired && !abortNow;
	assign finish = (state == dce_pkg::ST_EXEC) && commandDone &&
		!abortNow && !restoreFail;

	always_comb begin
		next_state = state;
		case (state)
			dce_pkg::ST_IDLE: begin
				if (cmdAccept) begin
					next_state = dce_pkg::ST_CHECK;
				end
			end
			dce_pkg::ST_CHECK: begin
				next_state = abortNow ? dce_pkg::ST_IDLE : dce_pkg::ST_EXEC;
			end
			dce_pkg::ST_EXEC: begin
				if (abortNow || restoreFail) begin
					next_state = dce_pkg::ST_IDLE;
				end else if (finish) begin
					next_state = isRead ? dce_pkg::ST_DRAIN : dce_pkg::ST_IDLE;
				end
			end
			dce_pkg::ST_DRAIN: begin
				if (bufferDrained) begin
					next_state = dce_pkg::ST_IDLE;
				end
			end
			default: begin
				next_state = dce_pkg::ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			state <= dce_pkg::ST_IDLE;
		end else begin
			state <= next_state;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			commandStart <= 1'b0;
		end else begin
			commandStart <= (state == dce_pkg::ST_CHECK) && !abortNow;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			commandAbort <= 1'b0;
		end else begin
			commandAbort <= abortNow || restoreFail;
		end
	end

	// interrupt on every abort, restore timeout and command end
	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			interruptRequestOut <= 1'b0;
		end else begin
			interruptRequestOut <= abortNow || restoreFail || finish;
		end
	end

	dce_step_counter u_steps (
		.clk_sys(clk_sys),
		.reset_n(reset_n),
		.restart(cmdAccept),
		.step(stepPulse && state == dce_pkg::ST_EXEC && isRestore),
		.atOrigin(headAtOriginInput),
		.expired(stepExpired)
	);

	////////////////////////////////////////////////////////////
	// Error flags

	always_comb begin
		errSet = 8'h00;
		if (state == dce_pkg::ST_EXEC) begin
			errSet[dce_pkg::ERR_BAD_BLOCK] = badBlockSeen;
			errSet[dce_pkg::ERR_DATA_CRC] = dataCrcFail;
			errSet[dce_pkg::ERR_HEADER] = headerMissing;
			errSet[dce_pkg::ERR_MARK] = markMissing && isRead;
		end
		errSet[dce_pkg::ERR_ABORT] = abortNow;
		errSet[dce_pkg::ERR_RESTORE] = restoreFail;
	end

	dce_sticky_flag #(
		.WIDTH(8)
	) u_errors (
		.clk_sys(clk_sys),
		.reset_n(reset_n),
		.clear(cmdAccept),
		.set(errSet),
		.flags(errFlags)
	);

	dce_sticky_flag #(
		.WIDTH(1)
	) u_corr (
		.clk_sys(clk_sys),
		.reset_n(reset_n),
		.clear(cmdAccept),
		.set(dataCorrected && running),
		.flags(corrFlag)
	);

	////////////////////////////////////////////////////////////
	// Status

	// not-ready abort latches the ready bit low
	always_ff @(posedge clk_sys) begin
		if (!reset_n || cmdAccept) begin
			readyLatched <= 1'b0;
		end else if (running && !driveReadyInput) begin
			readyLatched <= 1'b1;
		end
	end

	// fault abort latches the fault bit high
	always_ff @(posedge clk_sys) begin
		if (!reset_n || cmdAccept) begin
			faultLatched <= 1'b0;
		end else if (running && writeFaultInput) begin
			faultLatched <= 1'b1;
		end
	end

	always_comb begin
		statusWord = 8'h00;
		statusWord[dce_pkg::ST_BUSY] = busy;
		statusWord[dce_pkg::ST_READY] = driveReadyInput && !readyLatched;
		statusWord[dce_pkg::ST_FAULT] = writeFaultInput || faultLatched;
		statusWord[dce_pkg::ST_SEEK] = seekDoneInput;
		statusWord[dce_pkg::ST_XFER] = transferRequestInput;
		statusWord[dce_pkg::ST_CORR] = corrFlag;
		statusWord[dce_pkg::ST_RUN] = running;
		statusWord[dce_pkg::ST_ERROR] = |errFlags;
	end

	////////////////////////////////////////////////////////////
	// Checks

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!reset_n);

	sequence readEnd;
		state == dce_pkg::ST_EXEC && isRead && finish;
	endsequence

	sequence badCode;
		cmdAccept && (pwdata[7:4] != dce_pkg::CMD_RESTORE) &&
			(pwdata[7:4] != dce_pkg::CMD_READ) &&
			(pwdata[7:4] != dce_pkg::CMD_WRITE) &&
			(pwdata[7:4] != dce_pkg::CMD_SEEK);
	endsequence

	a_busy_on_write: assert property (cmdAccept |=> busy && statusWord[7])
		else $error("busy not raised after command write");

	a_abort_bad_code: assert property (badCode |-> ##2 errFlags[2] && !busy)
		else $error("unknown command not aborted");

	a_read_stays_busy: assert property (readEnd |=> busy && !running)
		else $error("read end dropped busy");

	a_fault_irq: assert property (state == dce_pkg::ST_EXEC && writeFaultInput
		|=> interruptRequestOut && errFlags[2] && statusWord[5])
		else $error("write fault not handled");

	a_ready_latch: assert property (running && !driveReadyInput
		|=> !statusWord[6] [*2])
		else $error("ready bit not latched low");

	a_restore_timeout: assert property (restoreFail |=> errFlags[1] && !busy)
		else $error("restore timeout flag missing");

	a_mark_flag: assert property (state == dce_pkg::ST_EXEC && isRead && markMissing
		|=> errFlags[0])
		else $error("missing mark not flagged");

	a_flags_clear: assert property (cmdAccept |=> errFlags == 8'h00)
		else $error("flags not cleared by command");

	a_error_summary: assert property (|errSet |=> statusWord[0])
		else $error("error summary not raised");

	a_reserved_zero: assert property (pready && paddr == dce_pkg::ADDR_ERROR && !pwrite
		|-> prdata[5] == 1'b0 && prdata[3] == 1'b0)
		else $error("reserved error bit read nonzero");
endmodule

// [common/dce_pkg.sv]
// Constants for the disk controller error and status bank.
// Assumes an APB master on clk_sys and a drive/engine that
// reports sector events as one-cycle pulses.
package dce_pkg;
	localparam logic [7:0] ADDR_ERROR = 8'h00;
	localparam logic [7:0] ADDR_STATUS = 8'h04;
	localparam logic [7:0] ADDR_COMMAND = 8'h08;

	localparam int ERR_BAD_BLOCK = 7;
	localparam int ERR_DATA_CRC = 6;
	localparam int ERR_HEADER = 4;
	localparam int ERR_ABORT = 2;
	localparam int ERR_RESTORE = 1;
	localparam int ERR_MARK = 0;
	localparam logic [7:0] ERR_USED_MASK = 8'hD7;

	localparam int ST_BUSY = 7;
	localparam int ST_READY = 6;
	localparam int ST_FAULT = 5;
	localparam int ST_SEEK = 4;
	localparam int ST_XFER = 3;
	localparam int ST_CORR = 2;
	localparam int ST_RUN = 1;
	localparam int ST_ERROR = 0;

	localparam logic [3:0] CMD_RESTORE = 4'h1;
	localparam logic [3:0] CMD_READ = 4'h2;
	localparam logic [3:0] CMD_WRITE = 4'h3;
	localparam logic [3:0] CMD_SEEK = 4'h7;

	localparam int STEP_WIDTH = 11;
	localparam logic [10:0] STEP_LIMIT = 11'h7FF;
	localparam logic [7:0] RESET_BYTE = 8'h00;

	typedef enum {
		ST_IDLE,
		ST_CHECK,
		ST_EXEC,
		ST_DRAIN
	} dce_state_t;
endpackage

// [rtl/dce_sticky_flag.sv]
// Bank of sticky flags with a common clear.
// Assumes set pulses and clear come from the clk_sys domain.
`timescale 1ns/1ps
module dce_sticky_flag #(
	parameter int WIDTH = 8
) (
	input wire logic clk_sys,
	input wire logic reset_n,
	input wire logic clear,
	input wire logic [WIDTH-1:0] set,
	output logic [WIDTH-1:0] flags
);
	// Set beats clear so a same-cycle event survives
	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			flags <= '0;
		end else begin
			flags <= (clear ? '0 : flags) | set;
		end
	end
endmodule

// [rtl/dce_step_counter.sv]
// Counts restore step pulses until the head reaches origin.
// Assumes step pulses last one cycle.
`timescale 1ns/1ps
module dce_step_counter (
	input wire logic clk_sys,
	input wire logic reset_n,
	input wire logic restart,
	input wire logic step,
	input wire logic atOrigin,
	output logic expired
);
	logic [dce_pkg::STEP_WIDTH-1:0] count;

	always_ff @(posedge clk_sys) begin
		if (!reset_n || restart) begin
			count <= '0;
		end else if (step && !atOrigin && !expired) begin
			count <= count + 1'b1;
		end
	end

	// Saturates, so a stuck drive cannot wrap the count
	assign expired = (count == dce_pkg::STEP_LIMIT) && !atOrigin;
endmodule

// [verification/dce_drive_model.sv]
// Drive and command engine stand-in for the disk error bank.
// Assumes start and abort pulses from the bank on clk_sys.
`timescale 1ns/1ps
module dce_drive_model (
	input wire logic clk_sys,
	input wire logic reset_n,
	input wire logic commandStart,
	input wire logic commandAbort,
	input wire logic [7:0] commandCode,
	input wire logic [7:0] lag,
	input wire logic [2:0] evSel,
	input wire logic homeOk,
	output logic stepPulse,
	output logic headAtOriginInput,
	output logic [5:0] evt
);
	logic [7:0] cnt;
	logic act;
	logic restore;
	always_ff @(posedge clk_sys) begin
		evt <= 6'h00;
		stepPulse <= 1'b0;
		if (!reset_n || commandAbort) begin
			act <= 1'b0;
			cnt <= 8'h00;
			headAtOriginInput <= 1'b0;
		end else if (commandStart) begin
			act <= 1'b1;
			cnt <= 8'h00;
			headAtOriginInput <= 1'b0;
			restore <= commandCode[7:4] == 4'h1;
		end else if (act) begin
			cnt <= cnt + 8'h01;
			if (restore) begin
				// Every other cycle keeps each step one cycle wide
				stepPulse <= cnt[0];
				if (homeOk && cnt == 8'h04) begin
					headAtOriginInput <= 1'b1;
				end
				if (homeOk && cnt == 8'h06) begin
					evt[5] <= 1'b1;
					act <= 1'b0;
				end
			end else if (cnt == lag && evSel != 3'h0) begin
				evt[evSel - 3'h1] <= 1'b1;
			end else if (cnt == lag + 8'h02) begin
				evt[5] <= 1'b1;
				act <= 1'b0;
			end
		end
	end
endmodule

// [verification/tb.sv]
// Self-checking bench for the disk error and status bank.
// Assumes the drive model on the far side and APB on clk_sys.
`timescale 1ns/1ps
module tb;
	logic clk_sys;
	logic reset_n = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic driveReadyInput = 1'b1;
	logic writeFaultInput = 1'b0;
	logic seekDoneInput = 1'b0;
	logic transferRequestInput = 1'b0;
	logic bufferDrained = 1'b0;
	logic [7:0] lag = 8'h04;
	logic [2:0] evSel = 3'h0;
	logic homeOk = 1'b1;
	logic stepPulse;
	logic headAtOriginInput;
	logic [5:0] evt;
	logic commandStart;
	logic [7:0] commandCode;
	logic commandAbort;
	logic interruptRequestOut;
	logic [11:0] steps;
	logic [31:0] seed = 32'hADED;
	logic [31:0] r;
	logic [32:0] q[$];
	logic [7:0] eb[4] = '{8'h80, 8'h40, 8'h10, 8'h01};
	logic [7:0] rec[3];
	int err_total = 0;
	int checked = 0;
	dce_error_status u_dce_error_status (.clk_sys(clk_sys), .reset_n(reset_n),
		.paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.driveReadyInput(driveReadyInput), .writeFaultInput(writeFaultInput),
		.seekDoneInput(seekDoneInput), .headAtOriginInput(headAtOriginInput),
		.stepPulse(stepPulse), .badBlockSeen(evt[0]), .dataCrcFail(evt[1]),
		.headerMissing(evt[2]), .markMissing(evt[3]),
		.transferRequestInput(transferRequestInput), .dataCorrected(evt[4]),
		.commandDone(evt[5]), .bufferDrained(bufferDrained), .commandStart(commandStart),
		.commandCode(commandCode), .commandAbort(commandAbort),
		.interruptRequestOut(interruptRequestOut));
	dce_drive_model u_dce_drive_model (.clk_sys(clk_sys), .reset_n(reset_n),
		.commandStart(commandStart), .commandAbort(commandAbort),
		.commandCode(commandCode), .lag(lag), .evSel(evSel), .homeOk(homeOk),
		.stepPulse(stepPulse), .headAtOriginInput(headAtOriginInput), .evt(evt));
////////////////////////////////////////////////////////////////////////////////
	initial begin
		clk_sys = 1'b0;
		forever #20 clk_sys = ~clk_sys;
	end
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	function automatic logic [32:0] stx(input logic [7:0] m);
		return {25'h0, m | {3'h0, seekDoneInput, transferRequestInput, 3'h0}};
	endfunction
	task automatic chk(input string s, input logic [32:0] v, input logic [32:0] e);
		checked++;
		if (v !== e) begin
			err_total++;
			$display("mismatch %s expected %h seen %h", s, e, v);
		end
	endtask
	task automatic stop_test;
		$display("checks %0d mismatches %0d", checked, err_total);
		if (err_total == 0 && checked > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
		input logic [32:0] e);
		int n;
		n = 0;
		if (!w) q.push_back(e);
		@(posedge clk_sys);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		@(posedge clk_sys);
		while (pready !== 1'b1) begin
			@(posedge clk_sys);
			n++;
			// A slave that never answers ends the run as a failure
			if (n > 20) begin
				err_total++;
				stop_test();
			end
		end
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [32:0] e);
		apb(1'b0, a, 32'h0, e);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d, 33'h0);
	endtask
	task automatic waitIrq(input logic ab);
		int n;
		n = 0;
		while (interruptRequestOut !== 1'b1 && n < 5000) begin
			@(posedge clk_sys);
			n++;
		end
		chk("irq", {32'h0, interruptRequestOut}, 33'h1);
		chk("abort", {32'h0, commandAbort}, {32'h0, ab});
	endtask
	task automatic cmd(input logic [7:0] c, input logic ab);
		wr(8'h08, {24'h0, c});
		waitIrq(ab);
	endtask
	task automatic levels;
		@(posedge clk_sys);
		r = xs();
		seekDoneInput <= r[0];
		transferRequestInput <= r[1];
		lag <= {4'h0, r[5:2]} + 8'h02;
		@(posedge clk_sys);
	endtask
////////////////////////////////////////////////////////////////////////////////
	// Read results are compared in the order they were requested
	always @(posedge clk_sys) begin
		if (psel && penable && pready === 1'b1 && !pwrite) begin
			chk("read", {pslverr, prdata}, q.pop_front());
			// Host result record: code, error copy, status copy
			if (paddr == 8'h00) rec[1] <= prdata[7:0];
			if (paddr == 8'h04) begin
				rec[0] <= prdata[0] ? 8'h06 : 8'h00;
				rec[2] <= prdata[7:0];
			end
		end
	end
	always @(posedge clk_sys) begin
		if (commandStart) steps <= 12'h000;
		else if (stepPulse) steps <= steps + 12'h001;
	end
	initial begin
		repeat (20000) @(posedge clk_sys);
		err_total++;
		stop_test();
	end
////////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (5) @(posedge clk_sys);
		reset_n <= 1'b1;
		levels();
		rd(8'h00, 33'h0);
		rd(8'h04, stx(8'h40));
		rd(8'h08, 33'h0);
		rd(8'h0C, 33'h1_0000_0000);
		wr(8'h00, xs());
		wr(8'h04, xs());
		rd(8'h00, 33'h0);
		driveReadyInput <= 1'b0;
		rd(8'h04, stx(8'h00));
		$display("test 1 done");
		for (int i = 0; i < 4; i++) begin
			levels();
			driveReadyInput <= 1'b1;
			evSel <= 3'(i + 1);
			cmd(8'h20, 1'b0);
			rd(8'h04, stx(8'hC1));
			rd(8'h00, {25'h0, eb[i]});
			// Refused while busy: old code must remain
			wr(8'h08, 32'h30);
			rd(8'h08, 33'h20);
			@(posedge clk_sys);
			bufferDrained <= 1'b1;
			@(posedge clk_sys);
			bufferDrained <= 1'b0;
			rd(8'h04, stx(8'h41));
		end
		$display("test 2 done");
		evSel <= 3'h5;
		cmd(8'h30, 1'b0);
		rd(8'h04, stx(8'h44));
		rd(8'h00, 33'h0);
		evSel <= 3'h0;
		cmd(8'h70, 1'b0);
		rd(8'h00, 33'h0);
		$display("test 3 done");
		driveReadyInput <= 1'b0;
		cmd(8'h70, 1'b1);
		driveReadyInput <= 1'b1;
		rd(8'h04, stx(8'h01));
		rd(8'h00, 33'h04);
		for (int c = 0; c < 16; c++) begin
			if (c != 1 && c != 2 && c != 3 && c != 7) begin
				r = xs();
				cmd({4'(c), r[3:0]}, 1'b1);
				rd(8'h00, 33'h04);
			end
		end
		$display("test 4 done");
		lag <= 8'h3C;
		for (int k = 0; k < 2; k++) begin
			wr(8'h08, 32'h30);
			rd(8'h04, stx(8'hC2));
			if (k == 1) writeFaultInput <= 1'b1;
			else driveReadyInput <= 1'b0;
			waitIrq(1'b1);
			writeFaultInput <= 1'b0;
			driveReadyInput <= 1'b1;
			rd(8'h04, stx(k == 1 ? 8'h61 : 8'h01));
			rd(8'h00, 33'h04);
		end
		$display("test 5 done");
		cmd(8'h10, 1'b0);
		rd(8'h00, 33'h0);
		homeOk <= 1'b0;
		cmd(8'h10, 1'b1);
		chk("steps", {21'h0, steps}, 33'd2047);
		rd(8'h00, 33'h02);
		rd(8'h04, stx(8'h41));
		@(posedge clk_sys);
		chk("result code", {25'h0, rec[0]}, 33'h06);
		chk("result copy", {17'h0, rec[1], rec[2]},
			{17'h0, 8'h02, 8'h41 | {3'h0, seekDoneInput, transferRequestInput, 3'h0}});
		$display("test 6 done");
		stop_test();
	end
endmodule
